// file: design/csi_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef CSI_MAP_SVH
`define CSI_MAP_SVH
`define CSI_OFS_MODE      4'h0
`define CSI_OFS_SHIFT     4'h1
`define CSI_OFS_BUSCTL    4'h2
`define CSI_OFS_PRESCALE  4'h3
`define CSI_OFS_STATUS    4'h4
`define CSI_OFS_MASK      4'h5
`define CSI_BIT_TXEN      7
`define CSI_BIT_RXEN      6
`define CSI_POS_MODE      2
`define CSI_POS_CLKSEL    0
`define CSI_BIT_START     0
`define CSI_BIT_STOP      1
`define CSI_RST_MODE      8'h00
`define CSI_RST_PRESCALE  8'h00
`define CSI_RST_MASK      8'h00
`define CSI_DIV_FIXED     16
`define CSI_DIV_PRESCALE0 64
`define CSI_STAT_DONE     0
`define CSI_STAT_START    1
`define CSI_STAT_STOP     2
`endif

// file: design/csi_pkg.sv
// types shared by the clocked serial channel
package csi_pkg;
    typedef enum logic [1:0] {
        MODE_3W_MSB, MODE_3W_LSB, MODE_2W_MSB, MODE_BAD
    } mode_e;
    typedef enum logic [1:0] {
        CLK_EXT, CLK_TIMER, CLK_PRESCALE, CLK_FIXED16
    } clksel_e;
    typedef struct packed {
        logic    tx_enable;
        logic    rx_enable;
        logic    spare;
        logic    spare2;
        mode_e   mode;
        clksel_e clksel;
    } mode_reg_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;
endpackage

// file: design/csi_channel.sv
// clocked serial channel: mode, clock select, shifter, two-wire triggers
`timescale 1ns/1ps
`include "csi_map.svh"
module csi_channel (
    input  wire logic       CORE_CLK,
    input  wire logic       RESET_N,
    input  wire logic [3:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       TIMER_OUT,
    input  wire logic       SERIAL_IN,
    input  wire logic       SCK_IN,
    output logic            SCK_OUT,
    output logic            SCK_OE,
    output logic            SERIAL_OUT,
    output logic            SDA_OE,
    output logic            IRQ
);
    csi_pkg::reg_req_s  req;
    csi_pkg::mode_reg_s mode_reg;
    logic [7:0] shift;
    logic [7:0] busctl;
    logic [7:0] prescale;
    logic [7:0] status;
    logic [7:0] mask;
    logic [2:0] bitcnt;
    logic       busy;
    logic       sck;
    logic [7:0] div_cnt;
    logic       ext_s1, ext_s2, ext_s3;
    logic       tmr_s1, tmr_s2, tmr_s3;
    logic       din_s1, din_s2, din_s3;
    logic [7:0] hp_cnt;

    assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

    wire wr_mode   = req.wr && req.addr == `CSI_OFS_MODE;
    wire wr_shift  = req.wr && req.addr == `CSI_OFS_SHIFT;
    wire wr_busctl = req.wr && req.addr == `CSI_OFS_BUSCTL;
    wire wr_pre    = req.wr && req.addr == `CSI_OFS_PRESCALE;
    wire wr_mask   = req.wr && req.addr == `CSI_OFS_MASK;
    wire rd_status = req.rd && req.addr == `CSI_OFS_STATUS;

    wire is_master = mode_reg.clksel != csi_pkg::CLK_EXT;
    wire lsb_first = mode_reg.mode == csi_pkg::MODE_3W_LSB;
    wire two_wire  = mode_reg.mode == csi_pkg::MODE_2W_MSB;
    wire mode_ok   = mode_reg.mode != csi_pkg::MODE_BAD;

    // prescaler value 0 selects the reset divide; else half period of n
    wire [7:0] pre_half = (prescale == `CSI_RST_PRESCALE)
                        ? 8'(`CSI_DIV_PRESCALE0 / 2) : prescale;
    wire [7:0] half_div = (mode_reg.clksel == csi_pkg::CLK_FIXED16)
                        ? 8'(`CSI_DIV_FIXED / 2) : pre_half;
    wire div_tick = div_cnt == half_div - 8'h01;

    // timer and clock-pin edges: an edge counts when stages two and three differ
    wire tmr_rise = tmr_s2 && !tmr_s3;
    wire ext_rise = ext_s2 && !ext_s3;
    wire ext_fall = !ext_s2 && ext_s3;

    // master half-period tick for each clock source
    wire half_tick = (mode_reg.clksel == csi_pkg::CLK_TIMER)
                   ? tmr_rise : div_tick;
    wire m_fall = busy && is_master && half_tick && sck;
    wire m_rise = busy && is_master && half_tick && !sck;
    wire s_fall = busy && !is_master && ext_fall;
    wire s_rise = busy && !is_master && ext_rise;
    wire out_edge = m_fall || s_fall;
    wire in_edge  = m_rise || s_rise;
    wire last_bit = in_edge && bitcnt == 3'h7;

    // start only with transmit enable already set and a legal mode
    wire start = wr_shift && mode_reg.tx_enable && mode_ok;

    wire [7:0] next_shift = lsb_first ? {din_s3, shift[7:1]}
                                      : {shift[6:0], din_s3};

    wire [7:0] events = {5'h00, wr_busctl && req.wdata[`CSI_BIT_STOP],
                         wr_busctl && req.wdata[`CSI_BIT_START],
                         last_bit};

    wire [7:0] rd_mux =
        (req.addr == `CSI_OFS_MODE)     ? mode_reg :
        (req.addr == `CSI_OFS_SHIFT)    ? shift :
        (req.addr == `CSI_OFS_BUSCTL)   ? busctl :
        (req.addr == `CSI_OFS_PRESCALE) ? prescale :
        (req.addr == `CSI_OFS_STATUS)   ? status :
        (req.addr == `CSI_OFS_MASK)     ? mask : 8'h00;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            // idle level of the clock pin is high: no false edge after reset
            {ext_s1, ext_s2, ext_s3} <= 3'h7;
            {tmr_s1, tmr_s2, tmr_s3} <= 3'h0;
            {din_s1, din_s2, din_s3} <= 3'h0;
        end else begin
            {ext_s1, ext_s2, ext_s3} <= {SCK_IN, ext_s1, ext_s2};
            {tmr_s1, tmr_s2, tmr_s3} <= {TIMER_OUT, tmr_s1, tmr_s2};
            {din_s1, din_s2, din_s3} <= {SERIAL_IN, din_s1, din_s2};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_reg <= `CSI_RST_MODE;
            prescale <= `CSI_RST_PRESCALE;
            mask     <= `CSI_RST_MASK;
        end else begin
            if (wr_mode) mode_reg <= req.wdata;
            if (wr_pre) prescale <= req.wdata;
            if (wr_mask) mask <= req.wdata;
        end
    end

    // triggers are held until the bus logic consumes them on a transfer
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busctl <= 8'h00;
        end else if (wr_busctl) begin
            busctl <= {6'h00, req.wdata[1:0]};
        end else if (start) begin
            busctl <= 8'h00;
        end
    end

    // divider runs off the core oscillator, so system dividers never matter
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_cnt <= 8'h00;
        end else if (div_tick || !busy) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // half-period length, watched by the clock-rate assertions
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hp_cnt <= 8'h00;
        end else if (start || m_fall || m_rise || !busy) begin
            hp_cnt <= 8'h00;
        end else begin
            hp_cnt <= hp_cnt + 8'h01;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy   <= 1'b0;
            sck    <= 1'b1;
            bitcnt <= 3'h0;
            shift  <= 8'h00;
        end else if (start) begin
            busy   <= 1'b1;
            sck    <= 1'b1;
            bitcnt <= 3'h0;
            shift  <= req.wdata;
        end else begin
            if (m_fall || m_rise) sck <= !sck;
            if (in_edge) begin
                shift  <= next_shift;
                bitcnt <= bitcnt + 3'h1;
            end
            if (last_bit) busy <= 1'b0;
        end
    end

    // first bit is shown as soon as the byte is loaded
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SERIAL_OUT <= 1'b1;
        end else if (start) begin
            SERIAL_OUT <= lsb_first ? req.wdata[0] : req.wdata[7];
        end else if (out_edge && bitcnt != 3'h0) begin
            SERIAL_OUT <= lsb_first ? shift[0] : shift[7];
        end
    end

    // set wins over the read clear
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            status <= 8'h00;
        end else begin
            status <= (rd_status ? 8'h00 : status) | events;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= req.rd ? rd_mux : 8'h00;
        end
    end

    assign SCK_OUT = sck;
    assign SCK_OE  = is_master;
    // open-drain data line in two-wire mode: drive only low
    assign SDA_OE  = two_wire && !SERIAL_OUT;
    assign IRQ     = |(status & mask);

    a_bad_mode_refused: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (wr_shift && mode_reg.mode == csi_pkg::MODE_BAD && !busy) |=> !busy)
        else $error("transfer began in prohibited mode");

    a_start_needs_enable: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (wr_shift && !mode_reg.tx_enable && !busy) |=> !busy)
        else $error("transfer began without transmit enable");

    a_first_bit: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        start |=> SERIAL_OUT == (lsb_first ? $past(REG_WDATA[0])
                                           : $past(REG_WDATA[7])))
        else $error("first bit not shown at load");

    a_runs_clock: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        start |=> busy && bitcnt == 3'h0)
        else $error("shift write did not start clock");

    // the clock must rest high between frames or the peer sees a bit
    a_sck_idle: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        !busy |-> sck)
        else $error("serial clock not idle high");

    a_done_flag: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        last_bit |=> status[`CSI_STAT_DONE] && !busy)
        else $error("done flag missing after last bit");

    a_status_clear: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (rd_status && events == 8'h00) |=> status == 8'h00)
        else $error("status read did not clear");

    a_fixed_half: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (mode_reg.clksel == csi_pkg::CLK_FIXED16 && (m_fall || m_rise))
        |-> hp_cnt == 8'(`CSI_DIV_FIXED / 2 - 1))
        else $error("fixed half period wrong");

    a_pre_half: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (mode_reg.clksel == csi_pkg::CLK_PRESCALE
         && prescale == `CSI_RST_PRESCALE && (m_fall || m_rise))
        |-> hp_cnt == 8'(`CSI_DIV_PRESCALE0 / 2 - 1))
        else $error("default prescaler half period wrong");

    a_trigger_flag: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (wr_busctl && REG_WDATA[`CSI_BIT_START])
        |=> status[`CSI_STAT_START])
        else $error("start trigger write not flagged");

    a_busctl_clear: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        start |=> busctl == 8'h00)
        else $error("triggers not consumed by transfer");

    a_sda_open_drain: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        SDA_OE |-> two_wire && !SERIAL_OUT)
        else $error("data line driven outside two-wire low");

    a_fixed16: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        mode_reg.clksel == csi_pkg::CLK_FIXED16 |-> half_div == 8'h08)
        else $error("fixed divider not sixteen");
    a_pre64: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        (mode_reg.clksel == csi_pkg::CLK_PRESCALE && prescale == 8'h00)
        |-> half_div == 8'h20)
        else $error("prescaler default not sixty four");
    a_busctl_upper: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        wr_busctl |=> busctl[7:2] == 6'h00
                      && busctl[1:0] == $past(REG_WDATA[1:0]))
        else $error("bus control upper bits not zero");
    a_slave_no_drive: assert property (@(posedge CORE_CLK)
        disable iff (!RESET_N)
        mode_reg.clksel == csi_pkg::CLK_EXT |-> !SCK_OE && !m_rise)
        else $error("slave drives clock");
endmodule

// file: tb/serial_peer.sv
// external serial peripheral model: captures the outgoing byte, sends one
`timescale 1ns/1ps
module serial_peer #(
    parameter logic [7:0] REPLY = 8'h35
) (
    input  wire logic       clk,
    input  wire logic       sck,
    input  wire logic       sck_oe,
    input  wire logic       sdo,
    output logic            sdi,
    output logic      [7:0] rx
);
    logic       sck_d;
    logic [2:0] cnt;
    initial begin
        sdi = 1'b0;
        rx = 8'h00;
        sck_d = 1'b1;
        cnt = 3'h0;
    end
    // sample on the rising serial clock edge, present on the falling one
    always @(posedge clk) begin
        sck_d <= sck;
        if (sck_oe && sck && !sck_d) begin
            rx <= {rx[6:0], sdo};
        end
        if (sck_oe && !sck && sck_d) begin
            sdi <= REPLY[3'h7 - cnt];
            cnt <= cnt + 3'h1;
        end
    end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the clocked serial channel
`timescale 1ns/1ps
module tb_top;
    logic       clk;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       timer;
    logic       sdi;
    logic       sck;
    logic       sck_oe;
    logic       sdo;
    logic       irq;
    logic       sda_oe;
    logic [7:0] rx;
    logic [7:0] v;
    int         num_errors;
    int         n_compared;
    int         cycles;
    int         half;
    logic [20:0] regs [8];
    logic [39:0] xfers [5];

    csi_channel csi_channel_inst (.CORE_CLK(clk), .RESET_N(rst_n),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .TIMER_OUT(timer), .SERIAL_IN(sdi),
        .SCK_IN(1'b1), .SCK_OUT(sck), .SCK_OE(sck_oe),
        .SERIAL_OUT(sdo), .SDA_OE(sda_oe), .IRQ(irq));
    serial_peer serial_peer_inst (.clk(clk), .sck(sck), .sck_oe(sck_oe),
        .sdo(sdo), .sdi(sdi), .rx(rx));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // timer output rises every 8 cycles, so timer/2 gives 8-cycle halves
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles % 4 == 3) timer <= ~timer;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        {addr, wdata, wr, rd, rst_n, timer} = '0;
        {num_errors, n_compared, cycles} = '0;
        // {address, write data, write first, expected read}
        regs = '{{4'h0, 8'h00, 1'b0, 8'h00}, {4'h3, 8'h00, 1'b0, 8'h00},
                 {4'h5, 8'h00, 1'b0, 8'h00}, {4'h2, 8'hFF, 1'b1, 8'h03},
                 {4'h0, 8'h83, 1'b1, 8'h83}, {4'h3, 8'h05, 1'b1, 8'h05},
                 {4'hF, 8'hAB, 1'b1, 8'h00}, {4'h5, 8'h01, 1'b1, 8'h01}};
        // {mode, data, byte seen by peer, byte received, half period}
        xfers = '{{8'h83, 8'h55, 8'h55, 8'h35, 8'd8},
                  {8'h87, 8'h01, 8'h80, 8'hAC, 8'd8},
                  {8'h81, 8'hA5, 8'hA5, 8'h35, 8'd8},
                  {8'h82, 8'hC3, 8'hC3, 8'h35, 8'd32},
                  {8'h8B, 8'h3A, 8'h3A, 8'h35, 8'd8}};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({4'h0, sck, sdo, irq, sck_oe}, 8'h0C);
        foreach (regs[i]) begin
            if (regs[i][8]) wr_reg(regs[i][20:17], regs[i][16:9]);
            rd_reg(regs[i][20:17], v);
            chk(v, regs[i][7:0]);
        end
        wr_reg(4'h3, 8'h00);
        rd_reg(4'h4, v);
        // shift write with transmit disabled must not clock anything
        wr_reg(4'h0, 8'h03);
        wr_reg(4'h1, 8'h55);
        half = 0;
        repeat (40) @(posedge clk) if (sck !== 1'b1) half = half + 1;
        chk(half[7:0], 8'h00);
        chk({7'h0, irq}, 8'h00);
        foreach (xfers[i]) begin
            wr_reg(4'h0, xfers[i][39:32]);
            wr_reg(4'h1, xfers[i][31:24]);
            half = 0;
            for (int k = 0; k < 200 && sck !== 1'b0; k++) @(negedge clk);
            while (half < 100 && sck !== 1'b1) begin
                @(negedge clk);
                half = half + 1;
            end
            chk(half[7:0], xfers[i][7:0]);
            for (int k = 0; k < 1200 && irq !== 1'b1; k++) @(negedge clk);
            chk({7'h0, irq}, 8'h01);
            // the peer sees the last rising clock one cycle after the design
            @(negedge clk);
            chk(rx, xfers[i][23:16]);
            v = {7'h0, xfers[i][35:34] == 2'b10 && !sdo};
            chk({7'h0, sda_oe}, v);
            rd_reg(4'h1, v);
            chk(v, xfers[i][15:8]);
            rd_reg(4'h4, v);
            chk(v & 8'h01, 8'h01);
            @(posedge clk);
            chk({7'h0, irq}, 8'h00);
        end
        close_out();
    end
endmodule
